//--- hdl/odtpd_pkg.sv
// constants and types for the termination and power-down control block
package odtpd_pkg;

  // clock of the block, in picoseconds per cycle
  localparam int CLK_PERIOD_PS = 4000;

  // termination disable / enable windows, latest edge, in ns
  localparam int TODTD_MAX_NS = 12;
  localparam int TODTE_MAX_NS = 12;

  // a longest time rounds down, never below one cycle
  function automatic int ns_to_cyc_floor(input int ns);
    int cyc;
    cyc = (ns * 1000) / CLK_PERIOD_PS;
    if (cyc < 1) begin
      cyc = 1;
    end
    return cyc;
  endfunction

  localparam int TODTD_CYC = ns_to_cyc_floor(TODTD_MAX_NS);
  localparam int TODTE_CYC = ns_to_cyc_floor(TODTE_MAX_NS);

  localparam int GATE_CNT_W = 4;
  localparam logic [GATE_CNT_W-1:0] TODTD_CNT = GATE_CNT_W'(TODTD_CYC);
  localparam logic [GATE_CNT_W-1:0] TODTE_CNT = GATE_CNT_W'(TODTE_CYC);

  // receivers stay on for two command clocks after cke falls
  localparam logic [1:0] TCPDED_CK = 2'h2;

  // read window counter
  localparam int RD_CNT_W = 7;
  localparam logic [RD_CNT_W-1:0] RD_CNT_MAX = 7'h7F;
  localparam logic [RD_CNT_W-1:0] RD_OFF_LEAD = 7'h02;

  // command address codes {ca2, ca1, ca0} with cs_n low and cke falling
  localparam logic [2:0] CA_DPD_CODE = 3'h3;
  localparam logic [2:0] CA_SREF_CODE = 3'h4;

  // strength field value that disables termination
  localparam logic [1:0] ODT_STRENGTH_OFF = 2'h0;

  typedef enum logic [1:0] {
    ST_ACTIVE,
    ST_PD,
    ST_SREF,
    ST_DPD
  } odtpd_state_type;

endpackage

//--- hdl/odtpd_pins_if.sv
// sampled command pins passed from the synchroniser to the controller
`timescale 1ns/100ps
interface odtpd_pins_if;
  logic ck_rise;
  logic cke;
  logic cs_n;
  logic [2:0] ca;

  modport sampler (output ck_rise, output cke, output cs_n, output ca);
  modport ctrl (input ck_rise, input cke, input cs_n, input ca);
endinterface

//--- hdl/odtpd_sync.sv
// two-flop synchronisers and command clock edge detection
`timescale 1ns/100ps
module odtpd_sync
  import odtpd_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ck_pin,
  input wire logic cke_pin,
  input wire logic cs_n_pin,
  input wire logic [2:0] ca_pin,
  odtpd_pins_if.sampler pins
);

  logic [5:0] meta_q;
  logic [5:0] sync_q;
  logic ck_prev_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_q <= 6'h00;
      sync_q <= 6'h00;
    end else begin
      meta_q <= {ca_pin, cs_n_pin, cke_pin, ck_pin};
      sync_q <= meta_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ck_prev_q <= 1'b0;
    end else begin
      ck_prev_q <= sync_q[0];
    end
  end

  // cke, cs_n and ca taken at the same synchronised ck edge
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pins.ck_rise <= 1'b0;
      pins.cke <= 1'b1;
      pins.cs_n <= 1'b1;
      pins.ca <= 3'h0;
    end else begin
      pins.ck_rise <= sync_q[0] & ~ck_prev_q;
      if (sync_q[0] & ~ck_prev_q) begin
        pins.cke <= sync_q[1];
        pins.cs_n <= sync_q[2];
        pins.ca <= sync_q[5:3];
      end
    end
  end

endmodule

//--- hdl/odtpd_ctrl.sv
// on-die termination gating and power-down entry/exit control
`timescale 1ns/100ps
module odtpd_ctrl
  import odtpd_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ck_pin,
  input wire logic cke_pin,
  input wire logic cs_n_pin,
  input wire logic [2:0] ca_pin,
  input wire logic odt_pin,
  input wire logic [1:0] odt_strength,
  input wire logic odt_pd_keep,
  input wire logic rd_cmd,
  input wire logic [5:0] read_latency,
  input wire logic [5:0] burst_len,
  input wire logic ca_train,
  input wire logic wr_level,
  input wire logic zq_cal,
  input wire logic dq_cal,
  input wire logic banks_open,
  output logic term_dq_en,
  output logic term_dqs_en,
  output logic [1:0] rtt_code,
  output logic in_pd,
  output logic in_active_pd,
  output logic in_sref,
  output logic in_dpd,
  output logic rcv_en,
  output logic refresh_hold,
  output logic rd_term_off
);

  odtpd_pins_if pins ();

  odtpd_sync u_sync (
    .clk(clk),
    .nrst(nrst),
    .ck_pin(ck_pin),
    .cke_pin(cke_pin),
    .cs_n_pin(cs_n_pin),
    .ca_pin(ca_pin),
    .pins(pins)
  );

  odtpd_state_type state_q;
  logic cke_prev_q;
  logic [1:0] cpded_q;
  logic rcv_en_q;
  logic active_pd_q;
  logic rd_busy_q;
  logic [RD_CNT_W-1:0] rd_cnt_q;
  logic [RD_CNT_W-1:0] rd_off_at;
  logic [RD_CNT_W-1:0] rd_on_at;
  logic rd_window;
  logic gate_q;
  logic [GATE_CNT_W-1:0] gate_cnt_q;
  logic gate_want;
  logic base_allow_q;
  logic dqs_allow_q;
  logic dq_allow_q;
  logic cke_fall;
  logic cke_rise;

  // cke edges seen on consecutive command clock rising edges
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cke_prev_q <= 1'b1;
    end else if (pins.ck_rise) begin
      cke_prev_q <= pins.cke;
    end
  end

  assign cke_fall = pins.ck_rise & cke_prev_q & ~pins.cke;
  assign cke_rise = pins.ck_rise & ~cke_prev_q & pins.cke;

  // power state; in a low power state no pin but ck and cke can change it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= ST_ACTIVE;
    end else begin
      case (state_q)
        ST_ACTIVE: begin
          if (cke_fall) begin
            if (pins.cs_n) begin
              state_q <= ST_PD;
            end else if (pins.ca == CA_DPD_CODE) begin
              state_q <= ST_DPD;
            end else if (pins.ca == CA_SREF_CODE) begin
              state_q <= ST_SREF;
            end
          end
        end
        ST_PD, ST_SREF, ST_DPD: begin
          if (cke_rise) begin
            state_q <= ST_ACTIVE;
          end
        end
        default: begin
          state_q <= ST_ACTIVE;
        end
      endcase
    end
  end

  // idle versus active power down, latched at entry
  always_ff @(posedge clk) begin
    if (!nrst) begin
      active_pd_q <= 1'b0;
    end else if (state_q == ST_ACTIVE && cke_fall && pins.cs_n) begin
      active_pd_q <= banks_open;
    end else if (state_q != ST_PD) begin
      active_pd_q <= 1'b0;
    end
  end

  // receivers kept alive across the cke path delay after entry
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cpded_q <= 2'h0;
      rcv_en_q <= 1'b1;
    end else if (state_q == ST_ACTIVE) begin
      cpded_q <= 2'h0;
      rcv_en_q <= 1'b1;
    end else if (cke_rise) begin
      // exit wakes the receivers at once, so the first command after exit is seen
      cpded_q <= 2'h0;
      rcv_en_q <= 1'b1;
    end else if (pins.ck_rise && rcv_en_q) begin
      if (cpded_q == TCPDED_CK - 2'h1) begin
        rcv_en_q <= 1'b0;
      end
      cpded_q <= cpded_q + 2'h1;
    end
  end

  // read window in command clocks from the read edge
  assign rd_off_at = RD_CNT_W'(read_latency) - RD_OFF_LEAD;
  assign rd_on_at = RD_CNT_W'(read_latency) + RD_CNT_W'(burst_len >> 1);
  assign rd_window = rd_busy_q && (rd_cnt_q >= rd_off_at);

  // a later read restarts the window from zero, so rd_window is low again until the new count reaches rd_off_at
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rd_busy_q <= 1'b0;
      rd_cnt_q <= 7'h00;
    end else if (rd_cmd) begin
      rd_busy_q <= 1'b1;
      rd_cnt_q <= 7'h00;
    end else if (rd_busy_q && pins.ck_rise) begin
      if (rd_cnt_q + 7'h01 >= rd_on_at || rd_cnt_q == RD_CNT_MAX) begin
        rd_busy_q <= 1'b0;
      end
      rd_cnt_q <= rd_cnt_q + 7'h01;
    end
  end

  // low power gate: follows entry and exit within the disable/enable windows
  always_comb begin
    case (state_q)
      ST_PD: gate_want = odt_pd_keep;
      ST_SREF: gate_want = 1'b0;
      ST_DPD: gate_want = 1'b0;
      default: gate_want = 1'b1;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      gate_q <= 1'b1;
      gate_cnt_q <= 4'h0;
    end else if (gate_want == gate_q) begin
      gate_cnt_q <= 4'h0;
    end else if (gate_cnt_q + 4'h1 >= (gate_q ? TODTD_CNT : TODTE_CNT)) begin
      gate_q <= gate_want;
      gate_cnt_q <= 4'h0;
    end else begin
      gate_cnt_q <= gate_cnt_q + 4'h1;
    end
  end

  // registered permission; the pin itself is combined below without sampling
  always_ff @(posedge clk) begin
    if (!nrst) begin
      base_allow_q <= 1'b0;
    end else begin
      base_allow_q <= (odt_strength != ODT_STRENGTH_OFF) && gate_q && !rd_window
        && !ca_train && !zq_cal && !dq_cal;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      dq_allow_q <= 1'b0;
      dqs_allow_q <= 1'b0;
    end else begin
      dq_allow_q <= !wr_level;
      dqs_allow_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rtt_code <= 2'h0;
    end else begin
      rtt_code <= odt_strength;
    end
  end

  // analog turn-on/off slopes start at the pin edges, so no clock stage here
  assign term_dq_en = base_allow_q & dq_allow_q & odt_pin;
  assign term_dqs_en = base_allow_q & dqs_allow_q & odt_pin;

  assign in_pd = (state_q == ST_PD);
  assign in_active_pd = active_pd_q;
  assign in_sref = (state_q == ST_SREF);
  assign in_dpd = (state_q == ST_DPD);
  assign rcv_en = rcv_en_q;
  assign refresh_hold = (state_q == ST_PD);
  assign rd_term_off = rd_window;

endmodule

//--- tb/odtpd_assertions.sv
// assertions on the termination and power-down control ports
`timescale 1ns/100ps
module odtpd_assertions (
  input wire logic clk,
  input wire logic nrst,
  input wire logic odt_pin,
  input wire logic [1:0] odt_strength,
  input wire logic odt_pd_keep,
  input wire logic ca_train,
  input wire logic wr_level,
  input wire logic zq_cal,
  input wire logic dq_cal,
  input wire logic term_dq_en,
  input wire logic term_dqs_en,
  input wire logic in_pd,
  input wire logic in_sref,
  input wire logic in_dpd,
  input wire logic rcv_en,
  input wire logic refresh_hold,
  input wire logic rd_term_off
);
  wire logic term_any = term_dq_en | term_dqs_en;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // the pin gates the outputs with no clock in between
  a_pin_gates_term: assert property (!odt_pin |-> !term_any)
    else $error("termination on with pin low");
  a_strength_off: assert property (odt_strength == 2'h0 |=> !term_dqs_en)
    else $error("termination on with zero strength");
  a_mode_off: assert property (ca_train || zq_cal || dq_cal |=> !term_any)
    else $error("termination on in training or calibration");
  a_level_dq_off: assert property (wr_level |=> !term_dq_en)
    else $error("data termination on in leveling");
  a_read_off: assert property (rd_term_off |=> !term_any)
    else $error("termination on in read window");
  // eight cycles cover the disable window with margin
  a_sref_off: assert property (in_sref [*8] |-> !term_any)
    else $error("termination on in self refresh");
  a_dpd_off: assert property (in_dpd [*8] |-> !term_any)
    else $error("termination on in deep power down");
  a_pd_no_keep: assert property ((in_pd && !odt_pd_keep) [*8] |-> !term_any)
    else $error("termination on in power down");
  a_pd_no_refresh: assert property (refresh_hold == in_pd)
    else $error("refresh hold differs from power down");
  a_rcv_delay: assert property ($rose(in_pd) |-> rcv_en [*8])
    else $error("receivers off too early");
  a_exit_rcv_on: assert property ($fell(in_pd) |-> rcv_en)
    else $error("receivers off after exit");
endmodule
bind odtpd_ctrl odtpd_assertions u_odtpd_chk (.clk, .nrst, .odt_pin, .odt_strength, .odt_pd_keep,
  .ca_train, .wr_level, .zq_cal, .dq_cal, .term_dq_en, .term_dqs_en, .in_pd, .in_sref, .in_dpd,
  .rcv_en, .refresh_hold, .rd_term_off);

//--- tb/odtpd_host_model.sv
// controller-side model driving command clock, command pins and odt
`timescale 1ns/100ps
module odtpd_host_model (
  output logic ck_pin,
  output logic cke_pin,
  output logic cs_n_pin,
  output logic [2:0] ca_pin,
  output logic odt_pin
);
  initial begin
    ck_pin = 1'h0;
    cke_pin = 1'h1;
    cs_n_pin = 1'h1;
    ca_pin = 3'h7;
    odt_pin = 1'h0;
  end
  // one command per ck period; ck stands low between commands
  task automatic cyc(input logic cke, input logic cs_n, input logic [2:0] ca);
    cke_pin = cke;
    cs_n_pin = cs_n;
    // deselected lines carry no stale value
    ca_pin = cs_n ? ~ca_pin : ca;
    #40.3 ck_pin = 1'h1;
    #40 ck_pin = 1'h0;
  endtask
  task automatic nops(input logic cke, input int n);
    repeat (n) cyc(cke, 1'h1, 3'h7);
  endtask
  task automatic odt(input logic v);
    odt_pin = v;
  endtask
endmodule

//--- tb/odtpd_ctrl_tb.sv
// self-checking bench for the termination and power-down control block
`timescale 1ns/100ps
module odtpd_ctrl_tb
  import odtpd_pkg::*;
();
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic ck_pin, cke_pin, cs_n_pin, odt_pin;
  logic [2:0] ca_pin;
  logic [1:0] odt_strength = 2'h1;
  logic odt_pd_keep = 1'h0;
  logic rd_cmd = 1'h0;
  logic ca_train = 1'h0;
  logic wr_level = 1'h0;
  logic zq_cal = 1'h0;
  logic dq_cal = 1'h0;
  logic banks_open = 1'h0;
  logic [5:0] read_latency = 6'h04;
  logic [5:0] burst_len = 6'h08;
  logic term_dq_en, term_dqs_en, in_pd, in_active_pd, in_sref, in_dpd, rcv_en;
  logic refresh_hold, rd_term_off;
  logic [1:0] rtt_code;
  int errors = 0;
  int samples_checked = 0;
  odtpd_host_model M (.ck_pin, .cke_pin, .cs_n_pin, .ca_pin, .odt_pin);
  odtpd_ctrl DUT (.clk, .nrst, .ck_pin, .cke_pin, .cs_n_pin, .ca_pin, .odt_pin, .odt_strength,
    .odt_pd_keep, .rd_cmd, .read_latency, .burst_len, .ca_train, .wr_level, .zq_cal, .dq_cal,
    .banks_open, .term_dq_en, .term_dqs_en, .rtt_code, .in_pd, .in_active_pd, .in_sref, .in_dpd,
    .rcv_en, .refresh_hold, .rd_term_off);
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input string what, input logic [1:0] exp, input logic [1:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic t_modes();
    M.odt(1'h1);
    for (int s = 0; s < 4; s++) begin
      odt_strength = s[1:0];
      w(2);
      chk("dqs_term", s != 0, term_dqs_en);
      chk("rtt_code", s[1:0], rtt_code);
    end
    M.odt(1'h0);
    w(1);
    chk("pin_low", 1'h0, term_dq_en);
    M.odt(1'h1);
    w(1);
    chk("write_dq", 1'h1, term_dq_en);
    for (int i = 0; i < 4; i++) begin
      {wr_level, dq_cal, zq_cal, ca_train} = 4'h1 << i;
      w(2);
      chk("mode_dqs", i == 3, term_dqs_en);
      chk("mode_dq", 1'h0, term_dq_en);
    end
    M.odt(1'h0);
    w(1);
    chk("level_dqs", 1'h0, term_dqs_en);
    {wr_level, dq_cal, zq_cal, ca_train} = 4'h0;
    M.odt(1'h1);
    w(2);
    $display("test modes done");
  endtask
  task automatic t_read();
    rd_cmd = 1'h1;
    w(1);
    rd_cmd = 1'h0;
    M.nops(1'h1, 1);
    w(1);
    chk("rd_early", 1'h0, rd_term_off);
    M.nops(1'h1, 1);
    w(1);
    chk("rd_off", 1'h1, rd_term_off);
    chk("rd_term", 1'h0, term_dqs_en);
    M.nops(1'h1, 5);
    w(1);
    chk("rd_hold", 1'h1, rd_term_off);
    M.nops(1'h1, 1);
    w(1);
    chk("rd_end", 1'h0, rd_term_off);
    chk("rd_resume", 1'h1, term_dqs_en);
    $display("test read done");
  endtask
  task automatic t_pd(input logic k, input logic b);
    odt_pd_keep = k;
    banks_open = b;
    M.nops(1'h1, 1);
    M.cyc(1'h0, 1'h1, 3'h7);
    w(1);
    chk("pd", 1'h1, in_pd);
    chk("active_pd", b, in_active_pd);
    chk("no_refresh", 1'h1, refresh_hold);
    chk("rcv_hold", 1'h1, rcv_en);
    M.nops(1'h0, 2);
    w(4);
    chk("rcv_off", 1'h0, rcv_en);
    chk("pd_term", k, term_dqs_en);
    // a self refresh code while already down must be ignored
    M.cyc(1'h0, 1'h0, CA_SREF_CODE);
    w(1);
    chk("pd_stay", 2'h1, {in_sref, in_pd});
    // the command clock runs two cycles before cke comes back
    M.nops(1'h0, 2);
    M.cyc(1'h1, 1'h1, 3'h7);
    w(1);
    chk("pd_exit", 2'h1, {in_pd, rcv_en});
    w(4);
    chk("pd_term_back", 1'h1, term_dqs_en);
    M.nops(1'h1, 2);
    $display("test power down done");
  endtask
  task automatic t_deep(input logic [2:0] code);
    M.nops(1'h1, 1);
    M.cyc(1'h0, 1'h0, code);
    w(4);
    chk("deep_state", 2'h1, code == CA_SREF_CODE ? {in_dpd, in_sref} : {in_sref, in_dpd});
    chk("deep_term", 1'h0, term_dqs_en);
    M.nops(1'h0, 2);
    M.cyc(1'h1, 1'h1, 3'h7);
    w(4);
    chk("deep_exit", 2'h0, {in_sref, in_dpd});
    chk("deep_term_back", 1'h1, term_dqs_en);
    M.nops(1'h1, 2);
    $display("test deep state done");
  endtask
  initial begin
    w(10);
    nrst = 1'h1;
    w(6);
    t_modes();
    t_read();
    t_pd(1'h0, 1'h0);
    t_pd(1'h1, 1'h1);
    t_deep(CA_SREF_CODE);
    t_deep(CA_DPD_CODE);
    wrap_up();
  end
  // the tests need under 10 us; ten times that means a hang
  initial begin
    #100000;
    errors++;
    $display("watchdog expired");
    wrap_up();
  end
endmodule
